/* File: common/hcntb_pkg.sv */
package hcntb_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] HCNTB_ADDR_CTRL = 8'h00;
    localparam logic [7:0] HCNTB_ADDR_CMD = 8'h04;
    localparam logic [7:0] HCNTB_ADDR_STATUS = 8'h08;
    localparam logic [7:0] HCNTB_ADDR_INT_STAT = 8'h0C;
    localparam logic [7:0] HCNTB_ADDR_INT_MASK = 8'h10;
    // control bits
    localparam int HCNTB_CTRL_NOTIFY_BIT = 0;
    localparam int HCNTB_CTRL_TEXT_BIT = 1;
    localparam logic [1:0] HCNTB_CTRL_RST = 2'h0;
    // command bits (fetch reads back while pending, self clearing)
    localparam int HCNTB_CMD_FETCH_BIT = 0;
    // status field positions
    localparam int HCNTB_ST_EVENTS_LSB = 0;
    localparam int HCNTB_ST_SENT_BIT = 8;
    localparam int HCNTB_ST_BUSY_BIT = 9;
    localparam int HCNTB_ST_COUNT_LSB = 16;
    // interrupt bits and reset of the mask
    localparam int HCNTB_INT_NOTIFY = 0;
    localparam int HCNTB_INT_FETCH = 1;
    localparam int HCNTB_INT_DROP = 2;
    localparam logic [2:0] HCNTB_INT_RST = 3'h0;
    // event layout
    localparam int HCNTB_NUM_OP_EVENTS = 6;
    localparam int HCNTB_TEXT_EVENT = 6;
    // text buffer depth
    localparam logic [5:0] HCNTB_BUF_DEPTH = 6'h28;
    // ascii bytes of the two replies
    localparam logic [7:0] HCNTB_NOTE_ID0 = 8'h51;
    localparam logic [7:0] HCNTB_NOTE_ID1 = 8'h55;
    localparam logic [7:0] HCNTB_FETCH_ID0 = 8'h54;
    localparam logic [7:0] HCNTB_FETCH_ID1 = 8'h42;
    localparam logic [7:0] HCNTB_ASCII_ZERO = 8'h30;
    localparam logic [7:0] HCNTB_ASCII_SEMI = 8'h3B;

    // one byte of the outgoing host stream, or one decoded character
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } hcntb_byte_t;

    // reply sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_N_ID0, S_N_ID1, S_N_D2, S_N_D1, S_N_D0, S_N_END,
        S_F_ID0, S_F_ID1, S_F_STAT, S_F_CNT1, S_F_CNT0, S_F_CHAR, S_F_END
    } hcntb_state_t;
endpackage

/* File: design/hcntb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module hcntb_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] op_change,
    input wire logic [5:0] host_read,
    input wire logic host_cmd,
    input wire logic host_text_send_busy,
    input wire hcntb_pkg::hcntb_byte_t dec_char,
    output hcntb_pkg::hcntb_byte_t tx,
    input wire logic tx_ready,
    output logic irq
);
    logic [1:0] ctrl; // bit0 notify enable, bit1 text weight enable
    logic [2:0] int_stat; // sticky event flags
    logic [2:0] int_mask; // enables onto irq
    logic fetch_pend; // fetch requested, not yet started
    logic [5:0] op_ev; // operator event bits
    logic [6:0] reported; // bits already carried by a notification
    logic sent; // a notification is out and not yet fully read
    logic cmd_seen; // host talked after a fresh change since the last notification
    logic [6:0] note_val; // value carried by the notification in flight
    logic [7:0] mem [0:39]; // decoded text, linear
    logic [5:0] cnt; // characters held
    logic [5:0] snap; // count frozen for the reply
    logic [5:0] rd_idx; // next character to send
    logic in_fetch; // fetch reply in progress
    hcntb_pkg::hcntb_state_t state;
    logic [6:0] events;
    logic [6:0] new_bits;
    logic byte_slot;
    logic start_fetch;
    logic start_notify;
    logic buf_wr;
    logic buf_drop;
    logic fetch_done;
    logic apb_wr;
    logic [2:0] int_ev;
    logic [11:0] note_dig;
    logic [11:0] cnt_dig;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // split a value below 200 into three bcd digits
    function automatic logic [11:0] to_dec(input logic [7:0] v);
        logic [7:0] r;
        logic [3:0] h;
        logic [3:0] t;
        r = v;
        h = 4'h0;
        t = 4'h0;
        if (r >= 8'h64) begin
            r = r - 8'h64;
            h = 4'h1;
        end
        for (int k = 1; k < 10; k++) begin
            if (r >= 8'(10 * k)) begin
                t = 4'(k);
            end
        end
        r = r - 8'(10 * t);
        return {h, t, r[3:0]};
    endfunction

    // the text weight is a level: present while text waits and the option is on
    assign events = {ctrl[hcntb_pkg::HCNTB_CTRL_TEXT_BIT] & (cnt != 6'h00),
        op_ev};
    assign new_bits = events & ~reported;
    assign byte_slot = !tx.valid || tx_ready;
    assign start_fetch = (state == hcntb_pkg::S_IDLE) && fetch_pend;
    // fetch wins over a notification; a blocked notification simply waits
    assign start_notify = (state == hcntb_pkg::S_IDLE) && !fetch_pend
        && ctrl[hcntb_pkg::HCNTB_CTRL_NOTIFY_BIT] && (new_bits != 7'h00)
        && (!sent || cmd_seen);
    // decoder is never paused by display settings; only full buffer or fetch reply drops
    assign buf_wr = dec_char.valid && (cnt < hcntb_pkg::HCNTB_BUF_DEPTH) && !in_fetch;
    assign buf_drop = dec_char.valid && !buf_wr;
    assign fetch_done = (state == hcntb_pkg::S_F_END) && byte_slot;
    assign apb_wr = psel && penable && pwrite && pready;
    assign note_dig = to_dec({1'b0, note_val});
    assign cnt_dig = to_dec({2'b00, snap});
    assign int_ev = {buf_drop, fetch_done, start_notify};

    // operator event bits, one per item; set wins over the host read
    generate
        for (genvar i = 0; i < hcntb_pkg::HCNTB_NUM_OP_EVENTS; i++) begin : g_ev
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    op_ev[i] <= 1'b0;
                end else if (op_change[i]) begin
                    op_ev[i] <= 1'b1;
                end else if (host_read[i]) begin
                    op_ev[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // bookkeeping of what the host already knows about
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reported <= 7'h00;
            sent <= 1'b0;
            cmd_seen <= 1'b0;
            note_val <= 7'h00;
        end else begin
            if (start_notify) begin
                // all pending new bits go in one sum
                note_val <= new_bits;
                reported <= (reported | new_bits) & events;
                sent <= 1'b1;
                cmd_seen <= 1'b0;
            end else begin
                // bits read by the host drop out of the reported set
                reported <= reported & events;
                if ((reported & events) == 7'h00) begin
                    sent <= 1'b0;
                end
                // only a command after a fresh change releases it, never a stale one
                if (host_cmd && sent && (new_bits != 7'h00)) begin
                    cmd_seen <= 1'b1;
                end
            end
        end
    end

    // text buffer storage; no reset needed, count says what is valid
    always_ff @(posedge mclk) begin
        if (buf_wr) begin
            mem[cnt] <= dec_char.data;
        end
    end

    // character count and fetch bookkeeping
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 6'h00;
            snap <= 6'h00;
            in_fetch <= 1'b0;
            fetch_pend <= 1'b0;
        end else begin
            if (fetch_done) begin
                cnt <= 6'h00;
            end else if (buf_wr) begin
                cnt <= cnt + 6'h01;
            end
            if (start_fetch) begin
                snap <= cnt;
                in_fetch <= 1'b1;
            end else if (fetch_done) begin
                in_fetch <= 1'b0;
            end
            // a request during a reply is kept for after it
            if (apb_wr && paddr == hcntb_pkg::HCNTB_ADDR_CMD
                && pwdata[hcntb_pkg::HCNTB_CMD_FETCH_BIT]) begin
                fetch_pend <= 1'b1;
            end else if (start_fetch) begin
                fetch_pend <= 1'b0;
            end
        end
    end

    // reply sequencer: one byte per accepted slot on the stream
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= hcntb_pkg::S_IDLE;
            tx <= '0;
            rd_idx <= 6'h00;
        end else if (state == hcntb_pkg::S_IDLE) begin
            if (tx_ready) begin
                tx.valid <= 1'b0;
            end
            if (start_fetch) begin
                state <= hcntb_pkg::S_F_ID0;
                rd_idx <= 6'h00;
            end else if (start_notify) begin
                state <= hcntb_pkg::S_N_ID0;
            end
        end else if (byte_slot) begin
            tx.valid <= 1'b1;
            unique case (state)
                hcntb_pkg::S_N_ID0: begin
                    tx.data <= hcntb_pkg::HCNTB_NOTE_ID0;
                    state <= hcntb_pkg::S_N_ID1;
                end
                hcntb_pkg::S_N_ID1: begin
                    tx.data <= hcntb_pkg::HCNTB_NOTE_ID1;
                    state <= hcntb_pkg::S_N_D2;
                end
                hcntb_pkg::S_N_D2: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO | {4'h0, note_dig[11:8]};
                    state <= hcntb_pkg::S_N_D1;
                end
                hcntb_pkg::S_N_D1: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO | {4'h0, note_dig[7:4]};
                    state <= hcntb_pkg::S_N_D0;
                end
                hcntb_pkg::S_N_D0: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO | {4'h0, note_dig[3:0]};
                    state <= hcntb_pkg::S_N_END;
                end
                hcntb_pkg::S_N_END: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_SEMI;
                    state <= hcntb_pkg::S_IDLE;
                end
                hcntb_pkg::S_F_ID0: begin
                    tx.data <= hcntb_pkg::HCNTB_FETCH_ID0;
                    state <= hcntb_pkg::S_F_ID1;
                end
                hcntb_pkg::S_F_ID1: begin
                    tx.data <= hcntb_pkg::HCNTB_FETCH_ID1;
                    state <= hcntb_pkg::S_F_STAT;
                end
                hcntb_pkg::S_F_STAT: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO
                        | {7'h00, host_text_send_busy};
                    state <= hcntb_pkg::S_F_CNT1;
                end
                hcntb_pkg::S_F_CNT1: begin
                    // counts stay below 100, so the hundreds digit is dropped
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO | {4'h0, cnt_dig[7:4]};
                    state <= hcntb_pkg::S_F_CNT0;
                end
                hcntb_pkg::S_F_CNT0: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_ZERO | {4'h0, cnt_dig[3:0]};
                    state <= (snap == 6'h00) ? hcntb_pkg::S_F_END : hcntb_pkg::S_F_CHAR;
                end
                hcntb_pkg::S_F_CHAR: begin
                    tx.data <= mem[rd_idx];
                    rd_idx <= rd_idx + 6'h01;
                    if (rd_idx + 6'h01 == snap) begin
                        state <= hcntb_pkg::S_F_END;
                    end
                end
                hcntb_pkg::S_F_END: begin
                    tx.data <= hcntb_pkg::HCNTB_ASCII_SEMI;
                    state <= hcntb_pkg::S_IDLE;
                end
                default: begin
                    state <= hcntb_pkg::S_IDLE;
                end
            endcase
        end
    end

    // software settings written on the access edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= hcntb_pkg::HCNTB_CTRL_RST;
            int_mask <= hcntb_pkg::HCNTB_INT_RST;
        end else if (apb_wr) begin
            if (paddr == hcntb_pkg::HCNTB_ADDR_CTRL) begin
                ctrl <= pwdata[1:0];
            end
            if (paddr == hcntb_pkg::HCNTB_ADDR_INT_MASK) begin
                int_mask <= pwdata[2:0];
            end
        end
    end

    // sticky interrupt flags; a new event beats a write-one clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_stat <= hcntb_pkg::HCNTB_INT_RST;
            irq <= 1'b0;
        end else begin
            if (apb_wr && paddr == hcntb_pkg::HCNTB_ADDR_INT_STAT) begin
                int_stat <= (int_stat & ~pwdata[2:0]) | int_ev;
            end else begin
                int_stat <= int_stat | int_ev;
            end
            irq <= |(int_stat & int_mask);
        end
    end

    // read mux; unmapped addresses answer zero with an error
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        unique case (paddr)
            hcntb_pkg::HCNTB_ADDR_CTRL: next_prdata[1:0] = ctrl;
            hcntb_pkg::HCNTB_ADDR_CMD: next_prdata[0] = fetch_pend;
            hcntb_pkg::HCNTB_ADDR_STATUS: begin
                next_prdata[hcntb_pkg::HCNTB_ST_EVENTS_LSB +: 7] = events;
                next_prdata[hcntb_pkg::HCNTB_ST_SENT_BIT] = sent;
                next_prdata[hcntb_pkg::HCNTB_ST_BUSY_BIT] = (state != hcntb_pkg::S_IDLE);
                next_prdata[hcntb_pkg::HCNTB_ST_COUNT_LSB +: 6] = cnt;
            end
            hcntb_pkg::HCNTB_ADDR_INT_STAT: next_prdata[2:0] = int_stat;
            hcntb_pkg::HCNTB_ADDR_INT_MASK: next_prdata[2:0] = int_mask;
            default: next_pslverr = 1'b1;
        endcase
    end

    // apb answer is ready in the first access cycle, so no wait states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
            pslverr <= psel && !penable && next_pslverr;
        end
    end

    // checks
    sequence s_note_head;
        tx.valid && tx.data == hcntb_pkg::HCNTB_NOTE_ID0;
    endsequence
    property p_note_needs_enable;
        @(posedge mclk) disable iff (!nrst)
        start_notify |-> ctrl[hcntb_pkg::HCNTB_CTRL_NOTIFY_BIT];
    endproperty
    a_note_needs_enable: assert property (p_note_needs_enable)
        else $error("notify while off");
    property p_note_frame;
        @(posedge mclk) disable iff (!nrst)
        (start_notify && tx_ready) |=> ##1 s_note_head
            ##[1:8] (tx.data == hcntb_pkg::HCNTB_NOTE_ID1);
    endproperty
    a_note_frame: assert property (p_note_frame) else $error("notify frame wrong");
    property p_note_sum;
        @(posedge mclk) disable iff (!nrst)
        start_notify |=> (note_val == $past(new_bits)) && (note_val != 7'h00);
    endproperty
    a_note_sum: assert property (p_note_sum) else $error("notify value not the sum");
    property p_no_repeat;
        @(posedge mclk) disable iff (!nrst)
        (sent && !cmd_seen) |-> !start_notify;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("repeat notify");
    property p_text_gated;
        @(posedge mclk) disable iff (!nrst)
        events[hcntb_pkg::HCNTB_TEXT_EVENT]
            |-> ctrl[hcntb_pkg::HCNTB_CTRL_TEXT_BIT] && cnt != 6'h00;
    endproperty
    a_text_gated: assert property (p_text_gated)
        else $error("text weight without option");
    property p_op_cause;
        @(posedge mclk) disable iff (!nrst)
        (op_ev & ~$past(op_ev)) != 6'h00 |-> ($past(op_change) & op_ev & ~$past(op_ev)) != 6'h00;
    endproperty
    a_op_cause: assert property (p_op_cause)
        else $error("event bit without operator change");
    property p_full_drop;
        @(posedge mclk) disable iff (!nrst)
        (cnt == hcntb_pkg::HCNTB_BUF_DEPTH && !fetch_done) |=> cnt == hcntb_pkg::HCNTB_BUF_DEPTH;
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full buffer changed");
    property p_fetch_empties;
        @(posedge mclk) disable iff (!nrst)
        fetch_done |=> cnt == 6'h00 && state == hcntb_pkg::S_IDLE;
    endproperty
    a_fetch_empties: assert property (p_fetch_empties)
        else $error("buffer not emptied");
    property p_status_char;
        @(posedge mclk) disable iff (!nrst)
        (state == hcntb_pkg::S_F_STAT && byte_slot)
            |=> tx.data == (hcntb_pkg::HCNTB_ASCII_ZERO | {7'h00, $past(host_text_send_busy)});
    endproperty
    a_status_char: assert property (p_status_char) else $error("bad status character");
endmodule
`default_nettype wire

/* File: test/hcntb_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// host side byte sink: takes the reply stream and hands each byte on
module hcntb_host_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire hcntb_pkg::hcntb_byte_t tx,
    input wire logic slow, // stall mode: ready only one cycle in four
    output logic tx_ready,
    output logic got,
    output logic [7:0] got_data
);
    logic [1:0] pace; // stall pacing counter

    // ready pacing; a real host uart is not always able to take a byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pace <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            pace <= pace + 2'h1;
            tx_ready <= !slow || (pace == 2'h2);
        end
    end

    // a byte counts only when valid and ready meet at an edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            got <= 1'b0;
            got_data <= 8'h00;
        end else begin
            got <= tx.valid && tx_ready;
            got_data <= tx.data;
        end
    end
endmodule
`default_nettype wire

/* File: test/hcntb_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module hcntb_top_tb;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, host_cmd, busy, tx_ready, irq;
    logic slow, got;
    logic [7:0] paddr, got_data;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] op_change, host_read;
    hcntb_pkg::hcntb_byte_t dec_char, tx;
    logic [7:0] rx_q[$]; // bytes taken by the host
    int failures = 0;
    int check_count = 0;
    logic err;

    hcntb_top dut (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_change(op_change), .host_read(host_read),
        .host_cmd(host_cmd), .host_text_send_busy(busy), .dec_char(dec_char),
        .tx(tx), .tx_ready(tx_ready), .irq(irq));
    hcntb_host_model host (.mclk(mclk), .nrst(nrst), .tx(tx), .slow(slow),
        .tx_ready(tx_ready), .got(got), .got_data(got_data));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // collect host bytes in order
    always @(posedge mclk) begin
        if (got === 1'b1) begin
            rx_q.push_back(got_data);
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a wait that never ends
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // single cycle pulses on the event inputs
    task automatic pulse(input logic [5:0] op, input logic [5:0] hr, input logic hc);
        @(posedge mclk);
        op_change <= op;
        host_read <= hr;
        host_cmd <= hc;
        @(posedge mclk);
        op_change <= 6'h00;
        host_read <= 6'h00;
        host_cmd <= 1'b0;
    endtask

    task automatic send_char(input logic [7:0] c);
        @(posedge mclk);
        dec_char <= '{valid: 1'b1, data: c};
        @(posedge mclk);
        dec_char <= '{valid: 1'b0, data: 8'h00};
    endtask

    // wait for a whole reply, then make sure nothing trails it
    task automatic expect_str(input string s);
        int n;
        n = 0;
        while (rx_q.size() < s.len() && n < 800) begin
            @(posedge mclk);
            n++;
        end
        repeat (12) @(posedge mclk);
        check(rx_q.size(), s.len());
        for (int i = 0; i < s.len() && i < rx_q.size(); i++) begin
            check({24'h0, rx_q[i]}, {24'h0, s[i]});
        end
        rx_q.delete();
    endtask

    task automatic quiet(input int n);
        repeat (n) @(posedge mclk);
        check(rx_q.size(), 0);
    endtask

    task automatic t_reset();
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_INT_MASK, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0); // unmapped place is refused
        check({31'h0, err}, 32'h1);
        @(posedge mclk);
        check({31'h0, pready}, 32'h0); // ready stands one cycle only
        pulse(6'h01, 6'h00, 1'b0);
        quiet(40);
        pulse(6'h00, 6'h01, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_notify();
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_CTRL, 32'h1);
        pulse(6'h01, 6'h00, 1'b0);
        expect_str("QU001;");
        check({31'h0, irq}, 32'h0); // masked so still quiet
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_STATUS, 32'h0);
        check(rd, 32'h0000_0101);
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_INT_MASK, 32'h1);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_INT_STAT, 32'h1);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        pulse(6'h00, 6'h01, 1'b0);
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        // each remaining operator item on its own weight
        for (int i = 1; i < 6; i++) begin
            pulse(6'h01 << i, 6'h00, 1'b0);
            expect_str($sformatf("QU%03d;", 1 << i));
            pulse(6'h00, 6'h01 << i, 1'b0);
        end
        $display("notify test done");
    endtask

    task automatic t_merge();
        pulse(6'h06, 6'h00, 1'b0);
        expect_str("QU006;");
        pulse(6'h00, 6'h00, 1'b1);
        pulse(6'h08, 6'h00, 1'b0);
        quiet(40);
        pulse(6'h00, 6'h00, 1'b1);
        expect_str("QU008;");
        pulse(6'h00, 6'h0E, 1'b0);
        pulse(6'h00, 6'h00, 1'b1);
        quiet(40);
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        $display("merge test done");
    endtask

    task automatic t_text();
        slow <= 1'b1;
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_CTRL, 32'h3);
        send_char(8'h41);
        expect_str("QU064;");
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_CMD, 32'h1);
        expect_str("TB001A;");
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        $display("text test done");
    endtask

    task automatic t_full();
        string s;
        s = "TB140";
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 41; i++) begin
            send_char(8'h41 + 8'(i % 26));
            if (i < 40) s = {s, string'(8'h41 + 8'(i % 26))};
        end
        quiet(30);
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_STATUS, 32'h0);
        check(rd, 32'h0028_0000);
        apb(1'b0, hcntb_pkg::HCNTB_ADDR_INT_STAT, 32'h0);
        check({31'h0, rd[2]}, 32'h1);
        busy <= 1'b1;
        apb(1'b1, hcntb_pkg::HCNTB_ADDR_CMD, 32'h1);
        expect_str({s, ";"});
        busy <= 1'b0;
        $display("full buffer test done");
    endtask

    // hang guard, generous against the several hundred cycles expected
    initial begin
        #(100 * 40000);
        failures++;
        close_out();
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        op_change = 6'h00;
        host_read = 6'h00;
        host_cmd = 1'b0;
        busy = 1'b0;
        slow = 1'b0;
        dec_char = '{valid: 1'b0, data: 8'h00};
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        t_reset();
        t_notify();
        t_merge();
        t_text();
        t_full();
        close_out();
    end
endmodule
`default_nettype wire
